// file: rtl/fab_defs.vh
// Offsets, field positions, reset values and timing for the parameter bank
`ifndef FAB_DEFS_VH
`define FAB_DEFS_VH

`define FAB_ADDR_W 8
`define FAB_OFS_SHORTCUT 8'h00
`define FAB_OFS_SPEED_SET 8'h04
`define FAB_OFS_HARD_SPEED 8'h08
`define FAB_OFS_FULL_SCALE 8'h0c
`define FAB_OFS_SPEED_FB 8'h10
`define FAB_OFS_CURRENT_FB 8'h14
`define FAB_OFS_ANALOG_ONE 8'h18
`define FAB_OFS_ANALOG_TWO 8'h1c
`define FAB_OFS_ANALOG_THREE 8'h20
`define FAB_OFS_DIGITAL_IN 8'h24
`define FAB_OFS_GOOD_MSG 8'h28
`define FAB_OFS_BAD_MSG 8'h2c
`define FAB_OFS_MISSING_MSG 8'h30
`define FAB_OFS_BAD_WIDTH 8'h34
`define FAB_OFS_SYNC_CTRL 8'h38
`define FAB_OFS_SYNC_STATE 8'h3c
`define FAB_OFS_SYNC_OUT_EN 8'h40
`define FAB_OFS_LIMIT_CTRL 8'h44
`define FAB_OFS_ERR_STATUS 8'h48

`define FAB_BIT_SPEED_SHORTCUT 0
`define FAB_BIT_HARD_SHORTCUT 1
`define FAB_BIT_LIMIT_ERROR_MODE 0
`define FAB_BIT_OVER_RANGE 0
`define FAB_DIG_FAST_LO 3
`define FAB_DIG_FAST_HI 4
`define FAB_DIG_FAST_MASK 7'h18

`define FAB_RST_SHORTCUT 8'h00
`define FAB_RST_FULL_SCALE 32'h000005dc
`define FAB_RST_FULL_SCALE_IND 32'h00000bb8
`define FAB_RST_SYNC_CTRL 2'h0
`define FAB_MAX_SYNC_CTRL 2'h2
`define FAB_RST_SYNC_OUT_EN 8'h01

`define FAB_FB_SRC_P1 8'h00
`define FAB_FB_SRC_P2 8'h06
`define FAB_ANALOG_ONE_FS 16'h0fa0
`define FAB_ANALOG_TWO_FS 16'h07ff
`define FAB_MILLI_PER_RPM 10'h3e8

`define FAB_CLK_MHZ 50
`define FAB_FAST_TICK_US 250
`define FAB_SLOW_TICK_US 2000
`define FAB_FAST_TICK_CYCLES (`FAB_FAST_TICK_US * `FAB_CLK_MHZ)
`define FAB_SLOW_TICK_RATIO (`FAB_SLOW_TICK_US / `FAB_FAST_TICK_US)

`endif

// file: rtl/fab_tick_gen.v
// Fast and slow refresh tick generator
`timescale 1ns/1ns
module fab_tick_gen #(
	parameter integer FAST_CYCLES = 12500,
	parameter integer SLOW_RATIO = 8
) (
	input wire sys_clk,
	input wire rst,
	input wire clkEn,
	output reg tickFast_q,
	output reg tickSlow_q
);
	reg [15:0] cycleCnt_q;
	reg [7:0] fastCnt_q;

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			cycleCnt_q <= 16'h0000;
			fastCnt_q <= 8'h00;
			tickFast_q <= 1'b0;
			tickSlow_q <= 1'b0;
		end
		else if (clkEn)
		begin
			tickFast_q <= 1'b0;
			tickSlow_q <= 1'b0;
			if (cycleCnt_q == FAST_CYCLES[15:0] - 16'h0001)
			begin
				cycleCnt_q <= 16'h0000;
				tickFast_q <= 1'b1;
				if (fastCnt_q == SLOW_RATIO[7:0] - 8'h01)
				begin
					fastCnt_q <= 8'h00;
					tickSlow_q <= 1'b1;
				end
				else
					fastCnt_q <= fastCnt_q + 8'h01;
			end
			else
				cycleCnt_q <= cycleCnt_q + 16'h0001;
		end
	end
endmodule

// file: rtl/fab_event_counter.v
// Wrapping 32-bit event counter with software overwrite
`timescale 1ns/1ns
module fab_event_counter (
	input wire sys_clk,
	input wire rst,
	input wire clkEn,
	input wire load,
	input wire [31:0] loadValue,
	input wire countEvent,
	output reg [31:0] count_q
);
	// An event beside a write still counts on top of the written value
	always @(posedge sys_clk)
	begin
		if (rst)
			count_q <= 32'h00000000;
		else if (clkEn)
		begin
			if (load)
				count_q <= loadValue + {31'h00000000, countEvent};
			else if (countEvent)
				count_q <= count_q + 32'h00000001;
		end
	end
endmodule

// file: rtl/fab_param_bank.v
// Fast-access parameter bank between software and the motor drive
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "fab_defs.vh"
module fab_param_bank #(
	parameter integer FAST_TICK_CYCLES = `FAB_FAST_TICK_CYCLES,
	parameter integer SLOW_TICK_RATIO = `FAB_SLOW_TICK_RATIO
) (
	input wire sys_clk,
	input wire rst,
	input wire clkEn,
	input wire [`FAB_ADDR_W-1:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData_q,
	input wire closedLoopMode,
	input wire inductionMode,
	input wire moduleReset,
	input wire [7:0] feedbackSourceSelector,
	input wire [31:0] driveSpeedFeedback,
	input wire [31:0] driveCurrentValue,
	input wire [15:0] analogInOne,
	input wire [15:0] analogInTwo,
	input wire [15:0] analogInThree,
	input wire [6:0] digitalInRaw,
	input wire [6:0] digitalInInvert,
	input wire syncGoodMsg,
	input wire syncBadMsg,
	input wire syncMissingMsg,
	input wire syncBadWidth,
	input wire [7:0] syncStateIn,
	input wire motionTaskRunning,
	output reg [31:0] presetSpeedOne_q,
	output reg presetSpeedOneLoad_q,
	output reg [31:0] driveHardSpeedValue_q,
	output reg driveHardSpeedLoad_q,
	output reg [1:0] syncControl_q,
	output reg syncOutEnable_q,
	output reg overRange_q
);
	// Limit a signed set-point to plus or minus the full-scale in 0.001 rpm
	function [31:0] limitSpeed;
		input [31:0] value;
		input [31:0] fullScale;
		reg [32:0] absVal;
		reg [31:0] absFs;
		reg [41:0] limit;
		begin
			absVal = value[31] ? (33'h000000000 - {value[31], value})
				: {1'b0, value};
			absFs = fullScale[31] ? (32'h00000000 - fullScale) : fullScale;
			limit = absFs * {32'h00000000, `FAB_MILLI_PER_RPM};
			if ({9'h000, absVal} > limit)
				limitSpeed = value[31] ? (32'h00000000 - limit[31:0])
					: limit[31:0];
			else
				limitSpeed = value;
		end
	endfunction

	// True when a signed set-point lies beyond plus or minus full scale
	function overLimit;
		input [31:0] value;
		input [31:0] fullScale;
		begin
			overLimit = (limitSpeed(value, fullScale) != value);
		end
	endfunction

	// Saturate a signed analog sample to plus or minus its full scale
	function [15:0] satAnalog;
		input [15:0] sample;
		input [15:0] fullScale;
		begin
			if (!sample[15] && sample > fullScale)
				satAnalog = fullScale;
			else if (sample[15] && (16'h0000 - sample) > fullScale)
				satAnalog = 16'h0000 - fullScale;
			else
				satAnalog = sample;
		end
	endfunction

	reg [7:0] shortcutEnable_q;
	reg [31:0] speedSetpoint_q;
	reg [31:0] hardSpeed_q;
	reg [31:0] fullScale_q;
	reg [31:0] speedFeedback_q;
	reg [31:0] currentFeedback_q;
	reg [15:0] analogOne_q;
	reg [15:0] analogTwo_q;
	reg [15:0] analogThree_q;
	reg [6:0] digitalIn_q;
	reg [7:0] syncState_q;
	reg [7:0] syncOutEnReg_q;
	reg limitErrorMode_q;
	reg [31:0] rdData_d;

	wire tickFast;
	wire tickSlow;
	wire [3:0] cntEvent;
	wire [3:0] cntLoad;
	wire [31:0] cntValue [0:3];
	wire [6:0] digitalPolar;
	wire wrSpeed;
	wire wrHard;
	wire speedOver;
	wire hardOver;
	wire feedbackFromDrive;

	fab_tick_gen #(
		.FAST_CYCLES(FAST_TICK_CYCLES),
		.SLOW_RATIO(SLOW_TICK_RATIO)
	) tickGen (
		.sys_clk(sys_clk),
		.rst(rst),
		.clkEn(clkEn),
		.tickFast_q(tickFast),
		.tickSlow_q(tickSlow)
	);

	assign cntEvent = {syncBadWidth, syncMissingMsg, syncBadMsg, syncGoodMsg};
	assign cntLoad[0] = regWr && regAddr == `FAB_OFS_GOOD_MSG;
	assign cntLoad[1] = regWr && regAddr == `FAB_OFS_BAD_MSG;
	assign cntLoad[2] = regWr && regAddr == `FAB_OFS_MISSING_MSG;
	assign cntLoad[3] = regWr && regAddr == `FAB_OFS_BAD_WIDTH;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : gCnt
			// Good, bad, missing and bad-width sync counters
			fab_event_counter evtCnt (
				.sys_clk(sys_clk),
				.rst(rst),
				.clkEn(clkEn),
				.load(cntLoad[gi]),
				.loadValue(regWrData),
				.countEvent(cntEvent[gi]),
				.count_q(cntValue[gi])
			);
		end
	endgenerate

	assign digitalPolar = digitalInRaw ^ digitalInInvert;
	assign wrSpeed = regWr && regAddr == `FAB_OFS_SPEED_SET;
	assign wrHard = regWr && regAddr == `FAB_OFS_HARD_SPEED;
	assign speedOver = overLimit(regWrData, fullScale_q);
	assign hardOver = overLimit(regWrData, fullScale_q);
	assign feedbackFromDrive = feedbackSourceSelector == `FAB_FB_SRC_P1 ||
		feedbackSourceSelector == `FAB_FB_SRC_P2;

	// Software-written configuration
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			shortcutEnable_q <= `FAB_RST_SHORTCUT;
			fullScale_q <= `FAB_RST_FULL_SCALE;
			syncControl_q <= `FAB_RST_SYNC_CTRL;
			syncOutEnReg_q <= `FAB_RST_SYNC_OUT_EN;
			limitErrorMode_q <= 1'b0;
		end
		else if (clkEn)
		begin
			if (moduleReset)
			begin
				if (closedLoopMode && inductionMode)
					fullScale_q <= `FAB_RST_FULL_SCALE_IND;
				else
					fullScale_q <= `FAB_RST_FULL_SCALE;
			end
			else if (regWr && regAddr == `FAB_OFS_FULL_SCALE)
				fullScale_q <= regWrData;
			if (regWr)
			begin
				case (regAddr)
					`FAB_OFS_SHORTCUT:
						shortcutEnable_q <= {6'h00, regWrData[1:0]};
					`FAB_OFS_SYNC_CTRL:
					begin
						if (regWrData[1:0] <= `FAB_MAX_SYNC_CTRL &&
							regWrData[31:2] == 30'h00000000)
							syncControl_q <= regWrData[1:0];
					end
					`FAB_OFS_SYNC_OUT_EN:
						syncOutEnReg_q <= regWrData[7:0];
					`FAB_OFS_LIMIT_CTRL:
						limitErrorMode_q <= regWrData[`FAB_BIT_LIMIT_ERROR_MODE];
					default:
						limitErrorMode_q <= limitErrorMode_q;
				endcase
			end
		end
	end

	// Set-points: clamped, or rejected with an error flag, against full scale
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			speedSetpoint_q <= 32'h00000000;
			hardSpeed_q <= 32'h00000000;
			overRange_q <= 1'b0;
		end
		else if (clkEn)
		begin
			if (wrSpeed)
			begin
				if (!limitErrorMode_q)
					speedSetpoint_q <= limitSpeed(regWrData, fullScale_q);
				else if (!speedOver)
					speedSetpoint_q <= regWrData;
			end
			if (wrHard)
			begin
				if (!limitErrorMode_q)
					hardSpeed_q <= limitSpeed(regWrData, fullScale_q);
				else if (!hardOver)
					hardSpeed_q <= regWrData;
			end
			// A new error beside a clear keeps the flag set
			if (limitErrorMode_q && ((wrSpeed && speedOver) ||
				(wrHard && hardOver)))
				overRange_q <= 1'b1;
			else if (regWr && regAddr == `FAB_OFS_ERR_STATUS &&
				regWrData[`FAB_BIT_OVER_RANGE])
				overRange_q <= 1'b0;
		end
	end

	// Forwarding to the drive on the fast tick
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			presetSpeedOne_q <= 32'h00000000;
			presetSpeedOneLoad_q <= 1'b0;
			driveHardSpeedValue_q <= 32'h00000000;
			driveHardSpeedLoad_q <= 1'b0;
		end
		else if (clkEn)
		begin
			presetSpeedOneLoad_q <= 1'b0;
			driveHardSpeedLoad_q <= 1'b0;
			if (tickFast && shortcutEnable_q[`FAB_BIT_SPEED_SHORTCUT])
			begin
				presetSpeedOne_q <= speedSetpoint_q;
				presetSpeedOneLoad_q <= 1'b1;
			end
			if (tickFast && closedLoopMode &&
				shortcutEnable_q[`FAB_BIT_HARD_SHORTCUT])
			begin
				driveHardSpeedValue_q <= hardSpeed_q;
				driveHardSpeedLoad_q <= 1'b1;
			end
		end
	end

	// Feedback mirrors from the drive
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			speedFeedback_q <= 32'h00000000;
			currentFeedback_q <= 32'h00000000;
			analogOne_q <= 16'h0000;
			analogTwo_q <= 16'h0000;
			analogThree_q <= 16'h0000;
			digitalIn_q <= 7'h00;
			syncState_q <= 8'h00;
		end
		else if (clkEn)
		begin
			syncState_q <= syncStateIn;
			if (tickFast)
			begin
				if (closedLoopMode && feedbackFromDrive)
					speedFeedback_q <= driveSpeedFeedback;
				currentFeedback_q <= driveCurrentValue;
				analogOne_q <= satAnalog(analogInOne,
					`FAB_ANALOG_ONE_FS);
				analogTwo_q <= satAnalog(analogInTwo,
					`FAB_ANALOG_TWO_FS);
				analogThree_q <= satAnalog(analogInThree,
					`FAB_ANALOG_TWO_FS);
				digitalIn_q[`FAB_DIG_FAST_HI:`FAB_DIG_FAST_LO] <=
					digitalPolar[`FAB_DIG_FAST_HI:`FAB_DIG_FAST_LO];
			end
			if (tickSlow)
			begin
				digitalIn_q[2:0] <= digitalPolar[2:0];
				digitalIn_q[6:5] <= digitalPolar[6:5];
			end
		end
	end

	// Output channels need a running motion task
	always @(posedge sys_clk)
	begin
		if (rst)
			syncOutEnable_q <= 1'b0;
		else if (clkEn)
			syncOutEnable_q <= (syncOutEnReg_q != 8'h00) &&
				motionTaskRunning;
	end

	// Read mux; unmapped offsets read zero
	always @*
	begin
		rdData_d = 32'h00000000;
		case (regAddr)
			`FAB_OFS_SHORTCUT:
				rdData_d = {24'h000000, shortcutEnable_q};
			`FAB_OFS_SPEED_SET:
				rdData_d = speedSetpoint_q;
			`FAB_OFS_HARD_SPEED:
				rdData_d = hardSpeed_q;
			`FAB_OFS_FULL_SCALE:
				rdData_d = fullScale_q;
			`FAB_OFS_SPEED_FB:
				rdData_d = speedFeedback_q;
			`FAB_OFS_CURRENT_FB:
				rdData_d = currentFeedback_q;
			`FAB_OFS_ANALOG_ONE:
				rdData_d = {{16{analogOne_q[15]}}, analogOne_q};
			`FAB_OFS_ANALOG_TWO:
				rdData_d = {{16{analogTwo_q[15]}}, analogTwo_q};
			`FAB_OFS_ANALOG_THREE:
				rdData_d = {{16{analogThree_q[15]}}, analogThree_q};
			`FAB_OFS_DIGITAL_IN:
				rdData_d = {24'h000000, 1'b0, digitalIn_q};
			`FAB_OFS_GOOD_MSG:
				rdData_d = cntValue[0];
			`FAB_OFS_BAD_MSG:
				rdData_d = cntValue[1];
			`FAB_OFS_MISSING_MSG:
				rdData_d = cntValue[2];
			`FAB_OFS_BAD_WIDTH:
				rdData_d = cntValue[3];
			`FAB_OFS_SYNC_CTRL:
				rdData_d = {30'h00000000, syncControl_q};
			`FAB_OFS_SYNC_STATE:
				rdData_d = {24'h000000, syncState_q};
			`FAB_OFS_SYNC_OUT_EN:
				rdData_d = {24'h000000, syncOutEnReg_q};
			`FAB_OFS_LIMIT_CTRL:
				rdData_d = {31'h00000000, limitErrorMode_q};
			`FAB_OFS_ERR_STATUS:
				rdData_d = {31'h00000000, overRange_q};
			default:
				rdData_d = 32'h00000000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk)
	begin
		if (rst)
			regRdData_q <= 32'h00000000;
		else if (clkEn)
			regRdData_q <= regRd ? rdData_d : 32'h00000000;
	end
endmodule

// file: dv/fab_param_bank_properties.sv
// Concurrent checks on the parameter bank's ports
`timescale 1ns/1ns
module fab_param_bank_props (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	input wire [31:0] regRdData_q,
	input wire closedLoopMode,
	input wire motionTaskRunning,
	input wire [31:0] presetSpeedOne_q,
	input wire presetSpeedOneLoad_q,
	input wire [31:0] driveHardSpeedValue_q,
	input wire driveHardSpeedLoad_q,
	input wire syncOutEnable_q,
	input wire overRange_q
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Each load must be followed by 8 cycles without a load, so loads come at least 9 cycles apart
	sequence s_presetQuiet;
		!presetSpeedOneLoad_q [*8];
	endsequence
	sequence s_hardQuiet;
		!driveHardSpeedLoad_q [*8];
	endsequence
	a_preset_load_gap: assert property (presetSpeedOneLoad_q |=> s_presetQuiet)
		else $error("preset load pulses too close");
	a_hard_load_gap: assert property (driveHardSpeedLoad_q |=> s_hardQuiet)
		else $error("hard speed load pulses too close");
	a_hard_needs_loop: assert property (driveHardSpeedLoad_q |-> $past(closedLoopMode))
		else $error("hard speed forwarded outside closed loop");
	a_preset_hold: assert property (!presetSpeedOneLoad_q |-> $stable(presetSpeedOne_q))
		else $error("preset speed changed without load");
	a_hard_hold: assert property (!driveHardSpeedLoad_q |-> $stable(driveHardSpeedValue_q))
		else $error("hard speed changed without load");
	a_sync_out_cause: assert property (syncOutEnable_q |-> $past(motionTaskRunning))
		else $error("sync output enabled without motion task");
	a_sync_out_drop: assert property (!motionTaskRunning |=> !syncOutEnable_q)
		else $error("sync output stayed on after motion task stop");
	a_digital_top_zero: assert property ($past(regRd) && $past(regAddr) == 8'h24
		|-> regRdData_q[31:7] == 25'h0)
		else $error("digital inputs upper bits not zero");
	a_shortcut_rsv_zero: assert property ($past(regRd) && $past(regAddr) == 8'h00
		|-> regRdData_q[31:2] == 30'h0)
		else $error("shortcut reserved bits not zero");
	a_over_clear: assert property ($fell(overRange_q)
		|-> $past(regWr && regAddr == 8'h48 && regWrData[0]))
		else $error("over-range flag cleared without write");
endmodule

bind fab_param_bank fab_param_bank_props i_props (
	.sys_clk(sys_clk),
	.rst(rst),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData_q(regRdData_q),
	.closedLoopMode(closedLoopMode),
	.motionTaskRunning(motionTaskRunning),
	.presetSpeedOne_q(presetSpeedOne_q),
	.presetSpeedOneLoad_q(presetSpeedOneLoad_q),
	.driveHardSpeedValue_q(driveHardSpeedValue_q),
	.driveHardSpeedLoad_q(driveHardSpeedLoad_q),
	.syncOutEnable_q(syncOutEnable_q),
	.overRange_q(overRange_q)
);

// file: dv/fab_drive_model.sv
// Drive-side model issuing one-cycle sync link event pulses
`timescale 1ns/1ns
module fab_drive_model (
	input wire logic sys_clk,
	input wire logic [3:0] evReq,
	output logic [3:0] evOut
);
	// Good, bad, missing, bad width: bits 0 to 3
	always @(posedge sys_clk)
		evOut <= evReq;
endmodule

// file: dv/fab_param_bank_tb_top.sv
// Self-checking bench for the fast-access parameter bank
`timescale 1ns/1ns
module fab_param_bank_tb_top;
	localparam int FT = 10;
	logic sys_clk = 0, rst = 1, regWr = 0, regRd = 0;
	logic loopM = 0, indM = 0, modRst = 0, motion = 0;
	logic [7:0] regAddr = 0, fbSel = 0, sst = 0;
	logic [31:0] regWrData = 0, spd = 0, cur = 0;
	logic [15:0] an1 = 0, an2 = 0, an3 = 0;
	logic [6:0] dRaw = 0, dInv = 0;
	logic [3:0] evReq = 0;
	wire [3:0] ev;
	wire [31:0] rdData, preset, hard;
	wire [1:0] sctl;
	wire presetLd, hardLd, soe, ovr;
	integer seed = 32'hcce9;
	int failCount = 0, compares = 0, v, k, cyc = 0;
	int m[73];
	int rw[11] = '{0, 4, 8, 12, 40, 44, 48, 52, 56, 64, 68};
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		cyc <= rst ? 0 : cyc + 1;
	fab_drive_model i_fab_drive_model (
		.sys_clk(sys_clk),
		.evReq(evReq),
		.evOut(ev)
	);
	fab_param_bank #(.FAST_TICK_CYCLES(FT)) i_fab_param_bank (
		.sys_clk(sys_clk),
		.rst(rst),
		.clkEn(1'b1),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWr(regWr),
		.regRd(regRd),
		.regRdData_q(rdData),
		.closedLoopMode(loopM),
		.inductionMode(indM),
		.moduleReset(modRst),
		.feedbackSourceSelector(fbSel),
		.driveSpeedFeedback(spd),
		.driveCurrentValue(cur),
		.analogInOne(an1),
		.analogInTwo(an2),
		.analogInThree(an3),
		.digitalInRaw(dRaw),
		.digitalInInvert(dInv),
		.syncGoodMsg(ev[0]),
		.syncBadMsg(ev[1]),
		.syncMissingMsg(ev[2]),
		.syncBadWidth(ev[3]),
		.syncStateIn(sst),
		.motionTaskRunning(motion),
		.presetSpeedOne_q(preset),
		.presetSpeedOneLoad_q(presetLd),
		.driveHardSpeedValue_q(hard),
		.driveHardSpeedLoad_q(hardLd),
		.syncControl_q(sctl),
		.syncOutEnable_q(soe),
		.overRange_q(ovr)
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
	begin
		compares++;
		if (g !== e)
		begin
			failCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	// Model update first, then one write cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int lim;
	begin
		lim = (m[12] < 0 ? -m[12] : m[12]) * 1000;
		if (a == 0)
			m[0] = d & 3;
		else if (a == 56)
			m[56] = d <= 2 ? d : m[56];
		else if (a >= 12 || $signed(d) <= lim && $signed(d) >= -lim)
			m[a] = d;
		else if ((m[68] & 1) == 0)
			m[a] = $signed(d) < 0 ? -lim : lim;
		@(posedge sys_clk);
		regWr <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWr <= 0;
	end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
	begin
		@(posedge sys_clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 0;
		@(negedge sys_clk);
		chk(rdData, e);
		@(negedge sys_clk);
		chk(rdData, 0);
		@(posedge sys_clk);
	end
	endtask
	// Bits 0 to 3 are link events, 4 is module reset
	task automatic pls(input int b);
	begin
		@(posedge sys_clk);
		{modRst, evReq} <= 5'h01 << b;
		@(posedge sys_clk);
		{modRst, evReq} <= 5'h00;
	end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic finalReport;
	begin
		$display("compares=%0d mismatches=%0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		failCount++;
		finalReport;
	end
	initial
	begin
		foreach (rw[i])
			m[rw[i]] = 0;
		m[12] = 1500;
		m[64] = 1;
		repeat (6) @(posedge sys_clk);
		rst <= 0;
		foreach (rw[i])
			rdc(rw[i], m[rw[i]]);
		$display("test reset values done");
		wr(0, $random(seed));
		rdc(0, m[0]);
		loopM <= 1;
		wr(0, 3);
		wr(4, $random(seed) % 1500000);
		wr(8, $random(seed) % 1500000);
		wt(2 * FT + 2);
		chk(preset, m[4]);
		chk(hard, m[8]);
		wr(0, 2);
		loopM <= 0;
		v = m[4];
		k = m[8];
		wr(4, ~v);
		wr(8, ~k);
		wt(2 * FT + 2);
		chk(preset, v);
		chk(hard, k);
		rdc(4, m[4]);
		loopM <= 1;
		$display("test forwarding done");
		wr(4, 2000000);
		rdc(4, m[4]);
		wr(8, -2000000);
		rdc(8, m[8]);
		wr(68, 1);
		wr(4, 1600000);
		rdc(4, m[4]);
		chk(ovr, 1);
		wr(72, 1);
		wt(1);
		chk(ovr, 0);
		for (k = 0; k < 2; k++)
		begin
			@(posedge sys_clk);
			indM <= !k;
			pls(4);
			m[12] = k ? 1500 : 3000;
			rdc(12, m[12]);
		end
		$display("test limits done");
		v = $random(seed);
		spd <= v;
		cur <= ~v;
		sst <= v[7:0];
		an1 <= 16'h1388;
		an2 <= 16'hf448;
		an3 <= 16'h0064;
		dRaw <= v[6:0];
		dInv <= v[13:7];
		fbSel <= 8'h06;
		wt(9 * FT);
		rdc(16, v);
		rdc(20, ~v);
		rdc(24, 32'h00000fa0);
		rdc(28, 32'hfffff801);
		rdc(32, 32'h00000064);
		rdc(36, v[6:0] ^ v[13:7]);
		rdc(60, v[7:0]);
		while (cyc % (8 * FT) != 3 * FT)
			@(posedge sys_clk);
		fbSel <= 8'h03;
		spd <= ~v;
		dRaw <= ~v[6:0];
		wt(2 * FT + 5);
		rdc(16, v);
		rdc(36, v[6:0] ^ v[13:7] ^ 7'h18);
		$display("test feedback done");
		for (k = 0; k < 4; k++)
			repeat (k + 1) pls(k);
		for (k = 0; k < 4; k++)
			rdc(40 + 4 * k, k + 1);
		wr(40, 32'h7fffffff);
		pls(0);
		rdc(40, 32'h80000000);
		wr(56, 2);
		wt(1);
		chk(sctl, 2);
		wr(56, 3);
		rdc(56, m[56]);
		chk(sctl, m[56]);
		$display("test counters done");
		motion <= 1;
		wt(3);
		chk(soe, 1);
		wr(64, 0);
		wt(2);
		chk(soe, 0);
		$display("test sync output done");
		finalReport;
	end
endmodule
